// ### logic/iec_chan_hold.v
// One-deep holding slot for a bus request channel.
// Assumes the consumer only takes the slot while it is full.
`timescale 1ns/1ns
module iec_chan_hold #(
    parameter W = 32
) (
    // Clock and reset
    input  wire         clk_i,
    input  wire         rst_n_i,
    // Source side
    input  wire         valid_i,
    input  wire [W-1:0] data_i,
    output wire         ready_o,
    // Consumer side
    input  wire         take_i,
    output wire         full_o,
    output wire [W-1:0] data_o
);

// ==========================================================
// Slot
reg         full;
reg [W-1:0] data;

assign ready_o = ~full;
assign full_o  = full;
assign data_o  = data;

always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        full <= 1'b0;
        data <= {W{1'b0}};
    end
    else if (valid_i && !full)
    begin
        full <= 1'b1;
        data <= data_i;
    end
    else if (take_i)
    begin
        full <= 1'b0;
    end
end

endmodule

// ### logic/iec_enable_bank.v
// Bank of per-interrupt enable flops, one per implemented bit.
// Assumes set and clear requests are one-cycle pulses on the core clock.
`timescale 1ns/1ns
module iec_enable_bank #(
    parameter         WIDTH = 32,
    parameter [WIDTH-1:0] MASK = {WIDTH{1'b1}}
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    // Requests
    input  wire [WIDTH-1:0] set_i,
    input  wire [WIDTH-1:0] clr_i,
    // State
    output wire [WIDTH-1:0] en_o
);

// ==========================================================
// Per-bit flops
genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
        if (MASK[i])
        begin : g_impl
            reg en;
            // Set wins so a concurrent enable is never lost
            wire next_en = set_i[i] | (en & ~clr_i[i]); // R2 R3
            always @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    en <= 1'b0; // R5
                else
                    en <= next_en;
            end
            assign en_o[i] = en;
        end
        else
        begin : g_hole
            assign en_o[i] = 1'b0; // R5
        end
    end
endgenerate

endmodule

// ### logic/iec_regs.vh
// Constants for the upper interrupt clear-enable words.
// Assumes byte addresses on a 32-bit register bus, one word per register.
`ifndef IEC_REGS_VH
`define IEC_REGS_VH

// ==========================================================
// Bus geometry
`define IEC_ADDR_W          12
`define IEC_DATA_W          32
`define IEC_STRB_W          4

// ==========================================================
// Register offsets
`define IEC_OFF_WORD_THREE  12'h008
`define IEC_OFF_WORD_FOUR   12'h00C

// ==========================================================
// Implemented bit masks and reset values
`define IEC_MASK_THREE      32'hFFFF3FFF
`define IEC_MASK_FOUR       4'hF
`define IEC_WIDTH_FOUR      4
`define IEC_RST_THREE       32'h00000000
`define IEC_RST_FOUR        4'h0

// ==========================================================
// Interrupt span of this slice
`define IEC_IRQ_COUNT       36

// ==========================================================
// Bus responses
`define IEC_RESP_OKAY       2'h0
`define IEC_RESP_SLVERR     2'h2

`endif

// ### logic/iec_top.v
// Clear-enable words for interrupts 64 to 99, reached over AXI4-Lite.
// Assumes the set-enable path shares the flops through IRQ_ENABLE_SET_I.
//
// Function
// R1 - Each bit maps one interrupt: word three 95..80 and 77..64, word four 99..96.
// R2 - Writing one to an implemented bit clears that interrupt's enable.
// R3 - Writing zero leaves the matching enable unchanged.
// R4 - Reads return the live enable state, one meaning enabled.
// R5 - Enables reset to zero; unimplemented bits read zero, software writes zero.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "iec_regs.vh"
module iec_top (
    // Clock and reset
    input  wire                       CORE_CLK_I,
    input  wire                       RST_N_I,
    // Write address channel
    input  wire                       S_AXI_AWVALID_I,
    input  wire [`IEC_ADDR_W-1:0]     S_AXI_AWADDR_I,
    output wire                       S_AXI_AWREADY_O,
    // Write data channel
    input  wire                       S_AXI_WVALID_I,
    input  wire [`IEC_DATA_W-1:0]     S_AXI_WDATA_I,
    input  wire [`IEC_STRB_W-1:0]     S_AXI_WSTRB_I,
    output wire                       S_AXI_WREADY_O,
    // Write response channel
    output wire                       S_AXI_BVALID_O,
    output wire [1:0]                 S_AXI_BRESP_O,
    input  wire                       S_AXI_BREADY_I,
    // Read address channel
    input  wire                       S_AXI_ARVALID_I,
    input  wire [`IEC_ADDR_W-1:0]     S_AXI_ARADDR_I,
    output wire                       S_AXI_ARREADY_O,
    // Read data channel
    output wire                       S_AXI_RVALID_O,
    output wire [`IEC_DATA_W-1:0]     S_AXI_RDATA_O,
    output wire [1:0]                 S_AXI_RRESP_O,
    input  wire                       S_AXI_RREADY_I,
    // Shared enable state
    input  wire [`IEC_IRQ_COUNT-1:0]  IRQ_ENABLE_SET_I,
    output wire [`IEC_IRQ_COUNT-1:0]  IRQ_ENABLE_O
);

// ==========================================================
// Declarations
wire                       aw_full;
wire [`IEC_ADDR_W-1:0]     aw_addr;
wire                       w_full;
wire [`IEC_DATA_W+`IEC_STRB_W-1:0] w_word;
wire [`IEC_DATA_W-1:0]     w_data;
wire [`IEC_STRB_W-1:0]     w_strb;
wire [`IEC_DATA_W-1:0]     w_bytes;
wire                       wr_fire;
wire [`IEC_ADDR_W-1:0]     wr_word_addr;
wire                       wr_hit_three;
wire                       wr_hit_four;
wire [31:0]                clr_three;
wire [`IEC_WIDTH_FOUR-1:0] clr_four;
wire [31:0]                en_three;
wire [`IEC_WIDTH_FOUR-1:0] en_four;
wire                       rd_fire;
wire [`IEC_ADDR_W-1:0]     rd_word_addr;
reg  [`IEC_DATA_W-1:0]     next_rdata;
reg  [1:0]                 next_rresp;
reg                        bvalid;
reg  [1:0]                 bresp;
reg                        rvalid;
reg  [`IEC_DATA_W-1:0]     rdata;
reg  [1:0]                 rresp;

// ==========================================================
// Write channels, taken in either order
iec_chan_hold #(
    .W       (`IEC_ADDR_W)
) u_aw_hold (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .valid_i (S_AXI_AWVALID_I),
    .data_i  (S_AXI_AWADDR_I),
    .ready_o (S_AXI_AWREADY_O),
    .take_i  (wr_fire),
    .full_o  (aw_full),
    .data_o  (aw_addr)
);

iec_chan_hold #(
    .W       (`IEC_DATA_W + `IEC_STRB_W)
) u_w_hold (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .valid_i (S_AXI_WVALID_I),
    .data_i  ({S_AXI_WSTRB_I, S_AXI_WDATA_I}),
    .ready_o (S_AXI_WREADY_O),
    .take_i  (wr_fire),
    .full_o  (w_full),
    .data_o  (w_word)
);

assign w_data = w_word[`IEC_DATA_W-1:0];
assign w_strb = w_word[`IEC_DATA_W+`IEC_STRB_W-1:`IEC_DATA_W];

// ==========================================================
// Write decode
// Waits for a free response slot so no answer is ever dropped
assign wr_fire      = aw_full & w_full & ~bvalid;
assign wr_word_addr = {aw_addr[`IEC_ADDR_W-1:2], 2'h0};
assign wr_hit_three = (wr_word_addr == `IEC_OFF_WORD_THREE);
assign wr_hit_four  = (wr_word_addr == `IEC_OFF_WORD_FOUR);

// Byte lanes not strobed never clear anything
assign w_bytes = {{8{w_strb[3]}},
                  {8{w_strb[2]}},
                  {8{w_strb[1]}},
                  {8{w_strb[0]}}};

// Only ones clear; zeros and holes leave state alone
assign clr_three = (wr_fire && wr_hit_three) ?
                   (w_data & w_bytes & `IEC_MASK_THREE) : 32'h00000000; // R2 R3 R5
assign clr_four  = (wr_fire && wr_hit_four) ?
                   (w_data[`IEC_WIDTH_FOUR-1:0] & w_bytes[`IEC_WIDTH_FOUR-1:0]
                    & `IEC_MASK_FOUR) : `IEC_RST_FOUR; // R2 R3 R5

// ==========================================================
// Enable flops, shared with the set-enable path
iec_enable_bank #(
    .WIDTH   (32),
    .MASK    (`IEC_MASK_THREE)
) u_bank_three (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .set_i   (IRQ_ENABLE_SET_I[31:0]),
    .clr_i   (clr_three),
    .en_o    (en_three)
);

iec_enable_bank #(
    .WIDTH   (`IEC_WIDTH_FOUR),
    .MASK    (`IEC_MASK_FOUR)
) u_bank_four (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .set_i   (IRQ_ENABLE_SET_I[`IEC_IRQ_COUNT-1:32]),
    .clr_i   (clr_four),
    .en_o    (en_four)
);

// Bit k of the vector is interrupt 64 + k
assign IRQ_ENABLE_O = {en_four, en_three}; // R1

// ==========================================================
// Write response
always @(posedge CORE_CLK_I or negedge RST_N_I)
begin
    if (!RST_N_I)
    begin
        bvalid <= 1'b0;
        bresp  <= `IEC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
        bvalid <= 1'b1;
        if (wr_hit_three || wr_hit_four)
            bresp <= `IEC_RESP_OKAY;
        else
            bresp <= `IEC_RESP_SLVERR;
    end
    else if (S_AXI_BREADY_I)
    begin
        bvalid <= 1'b0;
    end
end

assign S_AXI_BVALID_O = bvalid;
assign S_AXI_BRESP_O  = bresp;

// ==========================================================
// Read path
// One read in flight; address is refused until data is taken
assign S_AXI_ARREADY_O = ~rvalid;
assign rd_fire         = S_AXI_ARVALID_I & ~rvalid;
assign rd_word_addr    = {S_AXI_ARADDR_I[`IEC_ADDR_W-1:2], 2'h0};

always @*
begin
    next_rdata = 32'h00000000;
    next_rresp = `IEC_RESP_OKAY;
    case (rd_word_addr)
        `IEC_OFF_WORD_THREE:
        begin
            next_rdata = en_three & `IEC_MASK_THREE; // R4 R5
        end
        `IEC_OFF_WORD_FOUR:
        begin
            next_rdata = {28'h0000000, en_four}; // R4 R5
        end
        default:
        begin
            next_rresp = `IEC_RESP_SLVERR;
        end
    endcase
end

always @(posedge CORE_CLK_I or negedge RST_N_I)
begin
    if (!RST_N_I)
    begin
        rvalid <= 1'b0;
        rdata  <= 32'h00000000;
        rresp  <= `IEC_RESP_OKAY;
    end
    else if (rd_fire)
    begin
        rvalid <= 1'b1;
        rdata  <= next_rdata;
        rresp  <= next_rresp;
    end
    else if (S_AXI_RREADY_I)
    begin
        rvalid <= 1'b0;
    end
end

assign S_AXI_RVALID_O = rvalid;
assign S_AXI_RDATA_O  = rdata;
assign S_AXI_RRESP_O  = rresp;

endmodule

// ### sim/iec_top_monitor.sv
// Checker on the ports of the clear-enable word block.
// Assumes the offsets and masks of iec_regs.vh.
`timescale 1ns/1ns
`include "iec_regs.vh"
module iec_top_monitor (
    // Clock and reset
    input wire                      CORE_CLK_I,
    input wire                      RST_N_I,
    // Bus
    input wire                      S_AXI_BVALID_O,
    input wire                      S_AXI_ARVALID_I,
    input wire [`IEC_ADDR_W-1:0]    S_AXI_ARADDR_I,
    input wire                      S_AXI_ARREADY_O,
    input wire                      S_AXI_RVALID_O,
    input wire [`IEC_DATA_W-1:0]    S_AXI_RDATA_O,
    // Enables
    input wire [`IEC_IRQ_COUNT-1:0] IRQ_ENABLE_SET_I,
    input wire [`IEC_IRQ_COUNT-1:0] IRQ_ENABLE_O
);
    // ==========================================
    // Properties
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_spare_bits_low:
        assert property (IRQ_ENABLE_O[15:14] == 2'h0) else $error("spare enable set");
    a_set_lands:
        assert property (|IRQ_ENABLE_SET_I |=> (($past(IRQ_ENABLE_SET_I) & ~IRQ_ENABLE_O)
            & 36'hFFFFF3FFF) == 36'h0) else $error("set enable lost");
    // A drop is only legal as the side effect of a performed write
    a_drop_needs_write:
        assert property (($past(IRQ_ENABLE_O) & ~IRQ_ENABLE_O) != 36'h0 |-> S_AXI_BVALID_O)
            else $error("enable dropped without write");
    a_read_word_three:
        assert property ($rose(S_AXI_RVALID_O) && $past(S_AXI_ARADDR_I[11:2]) == 10'h002
            |-> S_AXI_RDATA_O == ($past(IRQ_ENABLE_O[31:0]) & `IEC_MASK_THREE))
            else $error("word three read wrong");
    a_read_word_four:
        assert property ($rose(S_AXI_RVALID_O) && $past(S_AXI_ARADDR_I[11:2]) == 10'h003
            |-> S_AXI_RDATA_O == {28'h0, $past(IRQ_ENABLE_O[35:32])})
            else $error("word four read wrong");
    a_read_answers:
        assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
            else $error("read not answered");
endmodule

bind iec_top iec_top_monitor i_mon (.CORE_CLK_I, .RST_N_I, .S_AXI_BVALID_O,
    .S_AXI_ARVALID_I, .S_AXI_ARADDR_I, .S_AXI_ARREADY_O, .S_AXI_RVALID_O,
    .S_AXI_RDATA_O, .IRQ_ENABLE_SET_I, .IRQ_ENABLE_O);

// ### sim/test_irq_enable_clear_upper_words.sv
// Self-checking bench for the clear-enable words over AXI4-Lite.
// Assumes the monitor is bound to iec_top; ready lines held high.
`timescale 1ns/1ns
`include "iec_regs.vh"
module test_irq_enable_clear_upper_words;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0, bready = 1, rready = 1;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0;
    logic [3:0]  ws = 0;
    logic [35:0] set = 0, e = 0;
    wire awr, wrdy, bv, arr, rv;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [35:0] en;
    int fail_count = 0, n_compared = 0;
    initial forever #4 clk = ~clk;
    iec_top i_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWADDR_I(awa), .S_AXI_AWREADY_O(awr), .S_AXI_WVALID_I(wv),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WREADY_O(wrdy),
        .S_AXI_BVALID_O(bv), .S_AXI_BRESP_O(br), .S_AXI_BREADY_I(bready),
        .S_AXI_ARVALID_I(arv), .S_AXI_ARADDR_I(ara), .S_AXI_ARREADY_O(arr),
        .S_AXI_RVALID_O(rv), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr),
        .S_AXI_RREADY_I(rready), .IRQ_ENABLE_SET_I(set), .IRQ_ENABLE_O(en));
    // ==========================================
    // Tasks
    task chk(input logic [35:0] g, input logic [35:0] x);
        n_compared++;
        if (g !== x)
        begin
            fail_count++;
            $display("Error t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task chk_resp(input logic [1:0] g, input logic [1:0] x);
        n_compared++;
        if (g !== x)
        begin
            fail_count++;
            $display("Error t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
        @(posedge clk);
        awv <= 1;
        wv <= 1;
        awa <= a;
        wd <= d;
        ws <= s;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrdy) wv <= 0;
        end while (!bv);
        chk_resp(br, r);
    endtask
    task rd(input [11:0] a, input [31:0] x, input [1:0] r);
        @(posedge clk);
        arv <= 1;
        ara <= a;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (!rv);
        chk(rdat, x);
        chk_resp(rr, r);
    endtask
    task pulse(input [35:0] s);
        @(posedge clk);
        set <= s;
        @(posedge clk);
        set <= 0;
        #1;
    endtask
    task rd_both;
        rd(`IEC_OFF_WORD_THREE, e[31:0] & 32'hFFFF3FFF, 2'h0);
        rd(`IEC_OFF_WORD_FOUR, {28'h0, e[35:32]}, 2'h0);
    endtask
    task give_verdict;
        if (fail_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================
    // Sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        chk(en, 36'h0);
        rd_both;
        pulse(36'hFFFFFFFFF);
        e = 36'hFFFFF3FFF;
        chk(en, e);
        rd_both;
        wr(`IEC_OFF_WORD_THREE, 32'h00010001, 4'hF, 2'h0);
        e[16] = 0;
        e[0] = 0;
        chk(en, e);
        wr(`IEC_OFF_WORD_THREE, 32'h0, 4'hF, 2'h0);
        chk(en, e);
        // Unstrobed lanes must not clear even with ones in them
        wr(`IEC_OFF_WORD_THREE, 32'hFFFFFFFF, 4'h8, 2'h0);
        e[31:24] = 0;
        chk(en, e);
        wr(`IEC_OFF_WORD_FOUR, 32'h5, 4'hF, 2'h0);
        e[32] = 0;
        e[34] = 0;
        chk(en, e);
        // Set held across the clearing edge must win
        set <= 36'h000000002;
        wr(`IEC_OFF_WORD_THREE, 32'h00000002, 4'hF, 2'h0);
        set <= 36'h000000000;
        chk(en, e);
        rd_both;
        wr(12'h010, 32'hFFFFFFFF, 4'hF, 2'h2);
        chk(en, e);
        rd(12'h010, 32'h0, 2'h2);
        pulse(36'h100000001);
        e[0] = 1;
        e[32] = 1;
        rd_both;
        // Reset held over several edges so the drop lies inside the reset
        @(posedge clk);
        rst_n <= 0;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        e = 0;
        chk(en, e);
        rd_both;
        give_verdict;
    end
    // Whole run is well under 200 cycles
    initial
    begin
        #20000;
        fail_count++;
        give_verdict;
    end
endmodule
